// [include/adcc_pkg.sv]
// Package with register map, field positions, reset values and timing for the conversion control block.
package adcc_pkg;
   // Register byte offsets on APB.
   localparam logic [7:0] OFS_RESULT_HIGH = 8'h00;
   localparam logic [7:0] OFS_RESULT_LOW  = 8'h04;
   localparam logic [7:0] OFS_MODE        = 8'h08;
   localparam logic [7:0] OFS_START       = 8'h0C;
   localparam logic [7:0] OFS_CLK_STOP    = 8'h10;
   localparam logic [7:0] OFS_IRQ_CTRL    = 8'h14;
   localparam logic [7:0] OFS_PORT_FUNC   = 8'h18;
   // Mode register fields.
   localparam int MODE_SPEED_BIT = 7;
   localparam int MODE_TRIGGER_ENABLE_BIT  = 6;
   localparam int CH_BASE_IN0    = 4;
   localparam int CH_BASE_IN4    = 8;
   // Start, clock stop and other control field positions.
   localparam int START_FLAG_BIT   = 7;
   localparam int STANDBY_BIT      = 4;
   localparam int EDGE_BIT         = 4;
   localparam int DONE_REQ_BIT     = 0;
   localparam int DONE_EN_BIT      = 1;
   localparam int PIN_FUNC_BIT     = 4;
   // Reset values.
   localparam logic [7:0] MODE_RST      = 8'h30;
   localparam logic [7:0] MODE_FIXED    = 8'h30;
   localparam logic [7:0] START_RST     = 8'h7F;
   localparam logic [7:0] START_FIXED   = 8'h7F;
   localparam logic [7:0] CLK_STOP_RST  = 8'hFF;
   // Conversion periods in system clocks.
   localparam logic [5:0] PERIOD_SLOW = 6'd62;
   localparam logic [5:0] PERIOD_FAST = 6'd31;
   // Converter state.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } adcc_state_t;
   // APB request group.
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } adcc_apb_req_t;
   // Comparator interface towards the analog ladder.
   typedef struct packed {
      logic       sample;
      logic [9:0] trial;
      logic [2:0] channel;
      logic       chan_valid;
      logic       powered;
   } adcc_ana_t;
endpackage : adcc_pkg

// [sim/adcc_top_test.sv]
// Self-checking testbench for the conversion control block, driven over APB and the trigger pin.
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
   $display("BAD %0t: got %h expected %h", $time, got, exp); end end

module adcc_top_test import adcc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk, srst, psel, penable, pwrite, trig, comp, pready, pslverr, done_irq, serr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   adcc_ana_t   ana;
   int          bad_count, check_count, n;

   // Device under test with every input driven by the bench.
   adcc_top i_adcc_top (
      .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .EXT_TRIGGER_PIN(trig), .COMP_HIGH(comp), .ANA(ana), .DONE_IRQ(done_irq)
   );

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Prints the verdict and ends the run; also the exit for any wait that runs out.
   task report_and_stop;
      if (bad_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   // One APB transfer; read data and error are taken at the edge where ready is sampled high.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         $display("BAD %0t: no ready", $time);
         report_and_stop();
      end
      serr = pslverr;
      rdat = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : bus

   // Counts cycles until the interrupt line rises; the bound keeps a dead converter from hanging the run.
   task wait_done(input int lo, input int hi);
      n = 0;
      while (done_irq !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      `CHK(n >= lo && n <= hi, 1'b1)
      if (n >= 200) report_and_stop();
   endtask : wait_done

   // Arms the trigger path, makes one pin transition and checks whether a conversion began.
   task trig_try(input logic [7:0] pf, input logic [7:0] md, input logic [7:0] ic, input logic from, input logic exp);
      trig <= from;
      repeat (5) @(posedge clk);
      bus(1'b1, OFS_PORT_FUNC, {24'h000000, pf});
      bus(1'b1, OFS_MODE, {24'h000000, md});
      bus(1'b1, OFS_IRQ_CTRL, {24'h000000, ic});
      trig <= ~from;
      repeat (5) @(posedge clk);
      bus(1'b0, OFS_START, 32'h00000000);
      `CHK(rdat[7], exp)
      bus(1'b1, OFS_START, 32'h00000000);
   endtask : trig_try

   // Main sequence.
   initial begin
      srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h00000000;
      trig = 1'b0; comp = 1'b1; bad_count = 0; check_count = 0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      // Reset values, fixed bits and an unmapped address.
      bus(1'b0, OFS_MODE, 32'h00000000);     `CHK(rdat[7:0], 8'h30)
      bus(1'b0, OFS_START, 32'h00000000);    `CHK(rdat[7:0], 8'h7F)
      bus(1'b0, OFS_CLK_STOP, 32'h00000000); `CHK(rdat[7:0], 8'hFF)
      `CHK(ana.chan_valid, 1'b0)
      bus(1'b0, 8'h3C, 32'h00000000);        `CHK({serr, rdat}, {1'b1, 32'h00000000})
      bus(1'b1, OFS_MODE, 32'h00000000);
      bus(1'b0, OFS_MODE, 32'h00000000);     `CHK(rdat[7:0], 8'h30)
      bus(1'b1, OFS_START, 32'h00000000);
      bus(1'b0, OFS_START, 32'h00000000);    `CHK(rdat[7:0], 8'h7F)
      // Every channel code, reserved ones included.
      for (int c = 0; c < 16; c++) begin
         bus(1'b1, OFS_MODE, {28'h0000000, c[3:0]});
         @(posedge clk);
         `CHK(ana.chan_valid, 1'(c >= 4 && c < 12))
         if (c >= 4 && c < 12) `CHK(ana.channel, 3'(c - 4))
      end
      // Fast conversion with an all-ones result and the interrupt enabled.
      bus(1'b1, OFS_MODE, 32'h00000085);
      bus(1'b1, OFS_IRQ_CTRL, 32'h00000002);
      comp <= 1'b1;
      bus(1'b1, OFS_START, 32'h00000080);
      wait_done(29, 33);
      bus(1'b0, OFS_START, 32'h00000000);       `CHK(rdat[7:0], 8'h7F)
      bus(1'b0, OFS_RESULT_HIGH, 32'h00000000); `CHK(rdat[7:0], 8'hFF)
      bus(1'b0, OFS_RESULT_LOW, 32'h00000000);  `CHK(rdat[7:6], 2'b11)
      bus(1'b0, OFS_IRQ_CTRL, 32'h00000000);    `CHK(rdat[1:0], 2'b11)
      bus(1'b1, OFS_IRQ_CTRL, 32'h00000002);
      @(posedge clk);
      `CHK(done_irq, 1'b0)
      // Slow conversion with an all-zeros result.
      bus(1'b1, OFS_MODE, 32'h00000005);
      comp <= 1'b0;
      bus(1'b1, OFS_START, 32'h00000080);
      wait_done(60, 64);
      bus(1'b0, OFS_RESULT_HIGH, 32'h00000000); `CHK(rdat[7:0], 8'h00)
      bus(1'b0, OFS_RESULT_LOW, 32'h00000000);  `CHK(rdat[7:6], 2'b00)
      // Completion with the interrupt masked still sets the request.
      bus(1'b1, OFS_IRQ_CTRL, 32'h00000000);
      bus(1'b1, OFS_START, 32'h00000080);
      repeat (70) @(posedge clk);
      `CHK(done_irq, 1'b0)
      bus(1'b0, OFS_IRQ_CTRL, 32'h00000000);    `CHK(rdat[1:0], 2'b01)
      bus(1'b1, OFS_IRQ_CTRL, 32'h00000002);
      // Busy flag and abort by writing zero.
      bus(1'b1, OFS_START, 32'h00000080);
      bus(1'b0, OFS_START, 32'h00000000);       `CHK(rdat[7:0], 8'hFF)
      bus(1'b1, OFS_START, 32'h00000000);
      bus(1'b0, OFS_START, 32'h00000000);       `CHK(rdat[7:0], 8'h7F)
      // External trigger gating and edge choice.
      trig_try(8'h10, 8'h05, 8'h12, 1'b0, 1'b0);
      trig_try(8'h10, 8'h45, 8'h12, 1'b0, 1'b1);
      trig_try(8'h00, 8'h45, 8'h12, 1'b0, 1'b0);
      trig_try(8'h10, 8'h45, 8'h02, 1'b0, 1'b0);
      trig_try(8'h10, 8'h45, 8'h02, 1'b1, 1'b1);
      // Module standby powers the ladder down and freezes the mode register.
      bus(1'b1, OFS_MODE, 32'h00000005);
      bus(1'b1, OFS_CLK_STOP, 32'h000000EF);
      bus(1'b0, OFS_CLK_STOP, 32'h00000000);    `CHK(rdat[7:0], 8'hEF)
      `CHK(ana.powered, 1'b0)
      bus(1'b1, OFS_MODE, 32'h00000089);
      bus(1'b0, OFS_MODE, 32'h00000000);        `CHK(rdat[7:0], 8'h35)
      bus(1'b1, OFS_CLK_STOP, 32'h000000FF);
      repeat (10) @(posedge clk);
      `CHK(ana.powered, 1'b1)
      // The result survives a reset in mid-run; mode and interrupt return to reset state.
      comp <= 1'b1;
      bus(1'b1, OFS_IRQ_CTRL, 32'h00000002);
      bus(1'b1, OFS_START, 32'h00000080);
      wait_done(60, 64);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      bus(1'b0, OFS_RESULT_HIGH, 32'h00000000); `CHK(rdat[7:0], 8'hFF)
      bus(1'b0, OFS_MODE, 32'h00000000);        `CHK(rdat[7:0], 8'h30)
      `CHK(done_irq, 1'b0)
      report_and_stop();
   end
endmodule : adcc_top_test

// [src/adcc_top.sv]
// Conversion control for an 8-channel 10-bit successive-approximation converter with an APB register file.
// What this block does
// - Trigger enable gates the external trigger pin.
// - Trigger edge taken from edge-select bit.
// - Mode bits 5 and 4 read one.
// - Channel field decode with no-channel reset.
// - Start flag write or trigger starts conversion.
// - Completion loads result, clears flag together.
// - Flag reads busy; writing zero aborts.
// - Start bits 6 to 0 read one.
// - Standby bit zero stops converter; resets one.
// - Successive approximation yields ten-bit result.
// - Completion sets request; enable gates interrupt.
// - Request set on flag falling at end.
// - Trigger needs pin function and enable.
// - Reset initialises mode, start and standby.
// - Result registers survive reset, undefined after power.
// - Speed bit selects 62 or 31 clocks.
// - Result split eight high, two low.
module adcc_top
   import adcc_pkg::*;
(
   // Clock and reset.
   input  wire logic        CLK,
   input  wire logic        SRST,
   // APB slave.
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // External trigger pin and comparator result.
   input  wire logic        EXT_TRIGGER_PIN,
   input  wire logic        COMP_HIGH,
   // Analog ladder control and interrupt request.
   output adcc_pkg::adcc_ana_t ANA,
   output logic             DONE_IRQ
);
   import adcc_pkg::*;

   logic [7:0]  mode_r, mode_nxt;
   logic        flag_r, flag_nxt;
   logic        standby_ctrl_r, standby_ctrl_nxt;
   logic        edge_sel_r, edge_sel_nxt;
   logic        pin_func_r, pin_func_nxt;
   logic        done_req_r, done_req_nxt;
   logic        done_en_r, done_en_nxt;
   logic [9:0]  result_r, result_nxt;
   logic [9:0]  sar_r, sar_nxt;
   logic [3:0]  bit_r, bit_nxt;
   logic [5:0]  cnt_r, cnt_nxt;
   logic        samp_r, samp_nxt;
   adcc_state_t state_r, state_nxt;
   logic        trg_s1_r, trg_s2_r, trg_s3_r;
   logic        trig_edge, wr, rd_en, busy_run, finish, start_req, abort_req;
   logic [7:0]  wbyte;
   logic [2:0]  chan;
   logic        chan_ok;
   logic [5:0]  period;
   logic [31:0] rdata_nxt;
   logic        addr_ok;

   // Trigger pin passes two flip-flops; the third stage only feeds the edge detector.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         trg_s1_r <= 1'b0;
         trg_s2_r <= 1'b0;
         trg_s3_r <= 1'b0;
      end else begin
         trg_s1_r <= EXT_TRIGGER_PIN;
         trg_s2_r <= trg_s1_r;
         trg_s3_r <= trg_s2_r;
      end
   end

   // Edge select: 1 picks rising, 0 picks falling; pin function, trigger enable and standby bit must all be set.
   assign trig_edge = pin_func_r && mode_r[MODE_TRIGGER_ENABLE_BIT] && standby_ctrl_r
                      && (edge_sel_r ? (trg_s2_r && !trg_s3_r) : (!trg_s2_r && trg_s3_r));

   // Channel decode; codes 00xx and 11xx leave no channel selected.
   always_comb begin
      chan    = 3'h0;
      chan_ok = 1'b0;
      if (mode_r[3:2] == 2'b01) begin
         chan    = {1'b0, mode_r[1:0]};
         chan_ok = 1'b1;
      end else if (mode_r[3:2] == 2'b10) begin
         chan    = {1'b1, mode_r[1:0]};
         chan_ok = 1'b1;
      end
   end

   assign period   = mode_r[MODE_SPEED_BIT] ? PERIOD_FAST : PERIOD_SLOW;
   assign wr       = PSEL && PENABLE && PWRITE;
   // Read data is picked in the setup cycle so that it already stands when PREADY is sampled high.
   assign rd_en    = PSEL && !PENABLE && !PWRITE;
   assign wbyte    = PWDATA[7:0];
   assign addr_ok  = (PADDR == OFS_RESULT_HIGH) || (PADDR == OFS_RESULT_LOW) || (PADDR == OFS_MODE)
                     || (PADDR == OFS_START) || (PADDR == OFS_CLK_STOP) || (PADDR == OFS_IRQ_CTRL)
                     || (PADDR == OFS_PORT_FUNC);
   assign start_req = (wr && PADDR == OFS_START && wbyte[START_FLAG_BIT]) || trig_edge;
   assign abort_req = wr && PADDR == OFS_START && !wbyte[START_FLAG_BIT];
   assign busy_run  = state_r == ST_CONV;
   assign finish    = busy_run && cnt_r == period - 6'd1 && !abort_req;

   // Register file writes. In standby the mode register holds its contents.
   always_comb begin
      mode_nxt         = mode_r;
      standby_ctrl_nxt = standby_ctrl_r;
      edge_sel_nxt     = edge_sel_r;
      pin_func_nxt     = pin_func_r;
      done_en_nxt      = done_en_r;
      done_req_nxt     = done_req_r;
      if (wr && PADDR == OFS_MODE && standby_ctrl_r) begin
         mode_nxt = (wbyte & ~MODE_FIXED) | MODE_FIXED;
      end
      if (wr && PADDR == OFS_CLK_STOP) begin
         standby_ctrl_nxt = wbyte[STANDBY_BIT];
      end
      if (wr && PADDR == OFS_IRQ_CTRL) begin
         edge_sel_nxt = wbyte[EDGE_BIT];
         done_en_nxt  = wbyte[DONE_EN_BIT];
         if (!wbyte[DONE_REQ_BIT]) begin
            done_req_nxt = 1'b0;
         end
      end
      if (wr && PADDR == OFS_PORT_FUNC) begin
         pin_func_nxt = wbyte[PIN_FUNC_BIT];
      end
      // Set wins over a clear in the same cycle.
      if (finish) begin
         done_req_nxt = 1'b1;
      end
   end

   // Successive approximation sequencer: sample phase, then one trial bit per step.
   always_comb begin
      state_nxt  = state_r;
      flag_nxt   = flag_r;
      cnt_nxt    = cnt_r;
      sar_nxt    = sar_r;
      bit_nxt    = bit_r;
      samp_nxt   = samp_r;
      result_nxt = result_r;
      case (state_r)
         ST_IDLE: begin
            if (start_req && standby_ctrl_r) begin
               state_nxt = ST_CONV;
               flag_nxt  = 1'b1;
               cnt_nxt   = 6'd0;
               sar_nxt   = 10'h200;
               bit_nxt   = 4'd9;
               samp_nxt  = 1'b1;
            end
         end
         ST_CONV: begin
            if (abort_req || !standby_ctrl_r) begin
               state_nxt = ST_IDLE;
               flag_nxt  = 1'b0;
               samp_nxt  = 1'b0;
            end else if (finish) begin
               state_nxt  = ST_IDLE;
               flag_nxt   = 1'b0;
               result_nxt = sar_r;
               samp_nxt   = 1'b0;
            end else begin
               cnt_nxt  = cnt_r + 6'd1;
               samp_nxt = 1'b0;
               // Trials resolve one bit per cycle after sampling; the rest of the period is settling.
               if (!samp_r && bit_r != 4'hF) begin
                  if (!COMP_HIGH) begin
                     sar_nxt[bit_r] = 1'b0;
                  end
                  if (bit_r != 4'd0) begin
                     sar_nxt[bit_r - 4'd1] = 1'b1;
                  end
                  bit_nxt = bit_r - 4'd1;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            flag_nxt  = 1'b0;
         end
      endcase
   end

   // Read mux; unmapped addresses return zero with an error.
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (PADDR == OFS_RESULT_HIGH) begin
         rdata_nxt[7:0] = result_r[9:2];
      end else if (PADDR == OFS_RESULT_LOW) begin
         rdata_nxt[7:6] = result_r[1:0];
      end else if (PADDR == OFS_MODE) begin
         rdata_nxt[7:0] = mode_r | MODE_FIXED;
      end else if (PADDR == OFS_START) begin
         rdata_nxt[7:0] = {flag_r, START_FIXED[6:0]};
      end else if (PADDR == OFS_CLK_STOP) begin
         rdata_nxt[7:0] = {3'h7, standby_ctrl_r, 4'hF};
      end else if (PADDR == OFS_IRQ_CTRL) begin
         rdata_nxt[7:0] = {3'h0, edge_sel_r, 2'h0, done_en_r, done_req_r};
      end else if (PADDR == OFS_PORT_FUNC) begin
         rdata_nxt[7:0] = {3'h0, pin_func_r, 4'h0};
      end
   end

   // Control state registers; result is outside reset so it survives it.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         mode_r         <= MODE_RST;
         flag_r         <= START_RST[START_FLAG_BIT];
         standby_ctrl_r <= CLK_STOP_RST[STANDBY_BIT];
         edge_sel_r     <= 1'b0;
         pin_func_r     <= 1'b0;
         done_req_r     <= 1'b0;
         done_en_r      <= 1'b0;
         state_r        <= ST_IDLE;
         cnt_r          <= 6'd0;
         sar_r          <= 10'h000;
         bit_r          <= 4'd0;
         samp_r         <= 1'b0;
      end else begin
         mode_r         <= mode_nxt;
         flag_r         <= flag_nxt;
         standby_ctrl_r <= standby_ctrl_nxt;
         edge_sel_r     <= edge_sel_nxt;
         pin_func_r     <= pin_func_nxt;
         done_req_r     <= done_req_nxt;
         done_en_r      <= done_en_nxt;
         state_r        <= state_nxt;
         cnt_r          <= cnt_nxt;
         sar_r          <= sar_nxt;
         bit_r          <= bit_nxt;
         samp_r         <= samp_nxt;
      end
   end

   // Result is held across reset, so it has no reset branch.
   always_ff @(posedge CLK) begin
      result_r <= result_nxt;
   end

   // Read data is registered at the end of the setup cycle and holds through the access cycle.
   // Loading it any later would hand the master stale data at the edge where it takes the answer.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         PRDATA <= 32'h0000_0000;
      end else if (rd_en) begin
         PRDATA <= rdata_nxt;
      end
   end

   // Zero-wait slave; ready and read data both stand in the first access cycle.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= PSEL && !PENABLE;
      end
   end

   assign PSLVERR         = PSEL && PENABLE && PREADY && !addr_ok;
   assign DONE_IRQ        = done_req_r && done_en_r;
   assign ANA.sample      = samp_r;
   assign ANA.trial       = sar_r;
   assign ANA.channel     = chan;
   assign ANA.chan_valid  = chan_ok;
   assign ANA.powered     = standby_ctrl_r;

   // Checks on the guarded behaviour.
   start_sets_a: assert property (@(posedge CLK) disable iff (SRST)
      (state_r == ST_IDLE && start_req && standby_ctrl_r) |=> flag_r)
      else $error("start did not set flag");
   finish_clear_a: assert property (@(posedge CLK) disable iff (SRST)
      finish |=> (!flag_r && result_r == $past(sar_r)))
      else $error("finish did not store result and clear flag");
   done_flag_a: assert property (@(posedge CLK) disable iff (SRST)
      finish |=> done_req_r)
      else $error("done request not set");
   abort_stop_a: assert property (@(posedge CLK) disable iff (SRST)
      (busy_run && abort_req) |=> (!flag_r && !done_req_r) or (!flag_r && $past(done_req_r)))
      else $error("abort did not stop");
   period_len_a: assert property (@(posedge CLK) disable iff (SRST)
      finish |-> cnt_r == (mode_r[MODE_SPEED_BIT] ? 6'd30 : 6'd61))
      else $error("wrong conversion period");
   irq_gate_a: assert property (@(posedge CLK) disable iff (SRST)
      DONE_IRQ == (done_req_r && done_en_r))
      else $error("interrupt not gated by enable");
   fixed_bits_a: assert property (@(posedge CLK) disable iff (SRST)
      mode_r[5:4] == 2'b11)
      else $error("fixed mode bits lost");
   trig_gate_a: assert property (@(posedge CLK) disable iff (SRST)
      trig_edge |-> (pin_func_r && mode_r[MODE_TRIGGER_ENABLE_BIT]))
      else $error("trigger accepted while disabled");

   // Standby must stop a running conversion, since the ladder is unpowered then.
   standby_abort_a: assert property (@(posedge CLK) disable iff (SRST)
      (busy_run && !standby_ctrl_r) |=> !flag_r)
      else $error("standby did not stop conversion");
   // Mode writes are dropped while in standby, so the register keeps its value.
   mode_hold_a: assert property (@(posedge CLK) disable iff (SRST)
      !standby_ctrl_r |=> mode_r == $past(mode_r))
      else $error("mode changed in standby");
   // Codes 00xx and 11xx must never drive a channel select onto the ladder.
   chan_none_a: assert property (@(posedge CLK) disable iff (SRST)
      (mode_r[3:2] == 2'b00 || mode_r[3:2] == 2'b11) |-> !chan_ok)
      else $error("reserved channel code selected");
   // The comparator samples once at the start of every conversion.
   sample_pulse_a: assert property (@(posedge CLK) disable iff (SRST)
      (state_r == ST_IDLE && start_req && standby_ctrl_r) |=> (ANA.sample && ANA.trial == 10'h200))
      else $error("conversion did not sample");
   // Reserved start bits always read as ones, whatever was written.
   start_bits_a: assert property (@(posedge CLK) disable iff (SRST)
      (rd_en && PADDR == OFS_START) |=> PRDATA[6:0] == START_FIXED[6:0])
      else $error("reserved start bits not one");
   // Ready is a single-cycle pulse per transfer.
   ready_pulse_a: assert property (@(posedge CLK) disable iff (SRST)
      PREADY |=> !PREADY)
      else $error("ready held too long");

   // Main scenarios to watch in the run; the bench never enters standby during a conversion.
   cover_fin_c: cover property (@(posedge CLK) disable iff (SRST) finish);
   cover_standby_c: cover property (@(posedge CLK) disable iff (SRST) busy_run && !standby_ctrl_r);
   cover_trig_c: cover property (@(posedge CLK) disable iff (SRST) trig_edge && !busy_run);
   cover_abort_c: cover property (@(posedge CLK) disable iff (SRST) busy_run && abort_req);
endmodule : adcc_top
